/* src/mode_regs_pkg.sv */
package mode_regs_pkg;

  // ----------------------------------------------------------------
  // register map (demultiplexed bus addresses, 5 address bits)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_OPERATION_MODE_CONTROL  = 5'h0f;
  localparam logic [4:0] ADDR_VERSION_AND_INIT_STATUS = 5'h1d;
  localparam logic [4:0] ADDR_MEMORY_ACCESS_COMMAND   = 5'h01;
  localparam logic [4:0] ADDR_MEMORY_ACCESS_ADDRESS   = 5'h02;
  localparam logic [4:0] ADDR_MEMORY_ACCESS_DATA      = 5'h03;
  localparam int          ADDR_BANK_BIT               = 4;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OMC_RESET         = 8'h00;
  localparam int          OMC_MODE_HI      = 7;
  localparam int          OMC_MODE_LO      = 6;
  localparam int          OMC_PCM_STBY     = 5;
  localparam int          OMC_PCM_LOOP     = 4;
  localparam int          OMC_OPEN_DRAIN   = 3;
  localparam int          OMC_MON_HS       = 2;
  localparam int          OMC_SUB_STBY     = 1;
  localparam int          OMC_BANK_SEL     = 0;
  localparam int          VNS_INIT_REQ     = 7;
  localparam int          VNS_SW_RESET     = 4;
  localparam logic [3:0]  CODE_UNASSIGNED  = 4'h0;
  localparam logic [3:0]  CMD_CLEAR_ALL    = 4'h7;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MEM_CLEAR = 2'b00,
    MODE_TEST      = 2'b01,
    MODE_INIT      = 2'b10,
    MODE_NORMAL    = 2'b11
  } op_mode_t;

  // ----------------------------------------------------------------
  // access durations in reference clock cycles (half cycles x2)
  // ----------------------------------------------------------------
  localparam int MEM_CLEAR_CYCLES  = 256;
  localparam int INIT_HALF_CYCLES  = 5;     // 2.5 cycles
  localparam int NORM_HALF_CYCLES  = 19;    // 9.5 cycles
  localparam int TRISTATE_CYCLES   = 1035;
  localparam int TEST_CYCLES       = 2057;
  // longest time: round down, at least one cycle
  localparam int INIT_CYCLES       = (INIT_HALF_CYCLES / 2 < 1) ? 1 : INIT_HALF_CYCLES / 2;
  localparam int NORM_CYCLES       = NORM_HALF_CYCLES / 2;
  localparam int CNT_W             = 12;

endpackage

/* src/mode_decoder.sv */
module mode_decoder
  import mode_regs_pkg::*;
(
  input  wire logic [7:0] omc,
  output logic             subscriber_run,
  output logic             pcm_run,
  output logic             pcm_tx_drive,
  output logic             subscriber_drive,
  output logic             mem_broadcast,
  output logic [11:0]      access_cycles
);
  op_mode_t mode;

  // ----------------------------------------------------------------
  // static decode of the mode control byte
  // ----------------------------------------------------------------
  always_comb begin
    mode             = op_mode_t'(omc[OMC_MODE_HI:OMC_MODE_LO]);
    subscriber_run   = (mode == MODE_NORMAL) || (mode == MODE_TEST);
    pcm_run          = subscriber_run;
    pcm_tx_drive     = subscriber_run && omc[OMC_PCM_STBY];
    subscriber_drive = subscriber_run && omc[OMC_SUB_STBY];
    mem_broadcast    = (mode == MODE_TEST);
    unique case (mode)
      MODE_MEM_CLEAR: access_cycles = 12'(MEM_CLEAR_CYCLES);
      MODE_INIT:     access_cycles = 12'(INIT_CYCLES);
      MODE_NORMAL:   access_cycles = 12'(NORM_CYCLES);
      MODE_TEST:     access_cycles = 12'(TEST_CYCLES);
    endcase
  end
endmodule

/* src/access_timer.sv */
module access_timer
  import mode_regs_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  busy,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             done_reg, done_next;

  // ----------------------------------------------------------------
  // down counter; a start while busy is ignored
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (cnt_reg != '0) begin
      cnt_next  = cnt_reg - 1'b1;
      done_next = (cnt_reg == CNT_W'(1));
    end else if (start) begin
      // start cycle is the first access cycle, else busy runs one too long
      cnt_next  = cycles - 1'b1;
      done_next = (cycles == CNT_W'(1));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;
endmodule

/* src/switch_mode_regs.sv */
module switch_mode_regs
  import mode_regs_pkg::*;
#(
  parameter logic [3:0] VERSION_CODE = 4'h5  // arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [4:0]  addr,
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic        demux_mode,
  input  wire logic [7:0]  wdata,
  output logic [7:0]       rdata,
  input  wire logic        clock_fault,
  input  wire logic        interrupt_event,
  input  wire logic        tristate_init_req,
  input  wire logic [3:0]  pcm_rx_pin,
  input  wire logic [3:0]  pcm_tx_data,
  input  wire logic [3:0]  pcm_tx_float,
  output logic [3:0]       pcm_rx_data,
  output logic [3:0]       pcm_tx_out,
  output logic [3:0]       pcm_tx_oe,
  output logic             tristate_control_pin,
  output logic             subscriber_oe,
  output logic             subscriber_open_drain,
  output logic             subscriber_run,
  output logic             pcm_run,
  output logic             monitor_handshake_select,
  output logic             mem_we,
  output logic             mem_broadcast,
  output logic [7:0]       mem_addr,
  output logic [7:0]       mem_data,
  output logic [3:0]       mem_code,
  output logic             mem_busy,
  output logic             external_reset_output
);
  import mode_regs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] omc_reg, omc_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] maddr_reg, maddr_next;
  logic [7:0] mdata_reg, mdata_next;
  logic       init_req_reg, init_req_next;
  logic       ext_rst_reg, ext_rst_next;
  logic       wr_d_reg, wr_d_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       clear_run_reg, clear_run_next;
  logic       tri_run_reg, tri_run_next;
  logic [3:0] rx_s1_reg, rx_s2_reg;
  logic       fault_s1_reg, fault_s2_reg;
  logic [3:0] rx_mux;
  logic [3:0] tx_oe_next, tx_out_next;
  logic       tctl_next;

  // decoded mode and timer
  logic             dec_sub_run, dec_pcm_run, dec_pcm_drive, dec_sub_drive, dec_bcast;
  logic [CNT_W-1:0] dec_cycles, timer_cycles;
  logic             timer_busy, timer_done, timer_start;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       wr_strobe, rd_sel;
  logic [4:0] eff_addr;
  logic       mode_is_reset;

  always_comb begin
    eff_addr = addr;
    if (demux_mode) begin
      eff_addr[ADDR_BANK_BIT] = addr[ADDR_BANK_BIT] | omc_reg[OMC_BANK_SEL];
    end
    wr_strobe     = !cs_n && !wr_n && !wr_d_reg;  // one write per low phase
    rd_sel        = !cs_n && !rd_n;
    mode_is_reset = (omc_reg[OMC_MODE_HI:OMC_MODE_LO] == MODE_MEM_CLEAR);
  end

  mode_decoder u_dec (
    .omc              (omc_reg),
    .subscriber_run   (dec_sub_run),
    .pcm_run          (dec_pcm_run),
    .pcm_tx_drive     (dec_pcm_drive),
    .subscriber_drive (dec_sub_drive),
    .mem_broadcast    (dec_bcast),
    .access_cycles    (dec_cycles)
  );

  // tristate field init uses its own, longer figure in normal mode
  assign timer_cycles = tri_run_next && !timer_busy ? 12'(TRISTATE_CYCLES) : dec_cycles;
  assign timer_start  = wr_strobe && (eff_addr == ADDR_MEMORY_ACCESS_COMMAND) && !timer_busy
                        || (tri_run_next && !tri_run_reg);

  access_timer u_tmr (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .start  (timer_start),
    .cycles (timer_cycles),
    .busy   (timer_busy),
    .done   (timer_done)
  );

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  always_comb begin
    omc_next       = omc_reg;
    cmd_next       = cmd_reg;
    maddr_next     = maddr_reg;
    mdata_next     = mdata_reg;
    init_req_next  = init_req_reg;
    ext_rst_next   = ext_rst_reg;
    clear_run_next = clear_run_reg;
    tri_run_next   = tri_run_reg;
    wr_d_next      = !cs_n && !wr_n;
    rdata_next     = 8'h00;
    if (wr_strobe && !timer_busy) begin
      unique case (eff_addr)
        ADDR_OPERATION_MODE_CONTROL:  omc_next   = wdata;
        ADDR_MEMORY_ACCESS_ADDRESS:   maddr_next = wdata;
        ADDR_MEMORY_ACCESS_DATA:      mdata_next = wdata;
        ADDR_MEMORY_ACCESS_COMMAND: begin
          cmd_next = wdata;
          if (mode_is_reset && wdata[7:4] == CMD_CLEAR_ALL) begin
            clear_run_next = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // write-only reset bit, held until an interrupt; other status bits ignore writes
    if (wr_strobe && eff_addr == ADDR_VERSION_AND_INIT_STATUS && wdata[VNS_SW_RESET]) begin
      ext_rst_next = 1'b1;
    end else if (interrupt_event) begin
      ext_rst_next = 1'b0;
    end
    if (tristate_init_req && !tri_run_reg && !timer_busy
        && omc_reg[OMC_MODE_HI:OMC_MODE_LO] == MODE_NORMAL) begin
      tri_run_next = 1'b1;
    end
    if (timer_done) begin
      if (clear_run_reg) begin
        init_req_next = 1'b0;
      end
      clear_run_next = 1'b0;
      tri_run_next   = 1'b0;
    end
    // fault sets, and set wins over the clear
    if (fault_s2_reg) begin
      init_req_next = 1'b1;
    end
    // reads return data only; no state changes
    if (rd_sel) begin
      unique case (eff_addr)
        ADDR_OPERATION_MODE_CONTROL:  rdata_next = omc_reg;
        ADDR_VERSION_AND_INIT_STATUS: rdata_next = {init_req_reg, 3'b000, VERSION_CODE};
        ADDR_MEMORY_ACCESS_COMMAND:   rdata_next = cmd_reg;
        ADDR_MEMORY_ACCESS_ADDRESS:   rdata_next = maddr_reg;
        ADDR_MEMORY_ACCESS_DATA:      rdata_next = mdata_reg;
        default:                      rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      tx_oe_next[i]  = dec_pcm_drive && !pcm_tx_float[i];
      tx_out_next[i] = pcm_tx_data[i];
      rx_mux[i]      = omc_reg[OMC_PCM_LOOP] ? pcm_tx_data[i] : rx_s2_reg[i];
    end
    tctl_next = dec_pcm_drive ? ~|tx_oe_next : 1'b1;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      omc_reg        <= OMC_RESET;
      cmd_reg        <= 8'h00;
      maddr_reg      <= 8'h00;
      mdata_reg      <= 8'h00;
      init_req_reg   <= 1'b1;  // power-up counts as a fault
      ext_rst_reg    <= 1'b0;
      wr_d_reg       <= 1'b0;
      rdata_reg      <= 8'h00;
      clear_run_reg  <= 1'b0;
      tri_run_reg    <= 1'b0;
      fault_s1_reg   <= 1'b0;
      fault_s2_reg   <= 1'b0;
      rx_s1_reg      <= 4'h0;
      rx_s2_reg      <= 4'h0;
      pcm_rx_data    <= 4'h0;
      pcm_tx_out     <= 4'h0;
      pcm_tx_oe      <= 4'h0;
      tristate_control_pin     <= 1'b1;
      subscriber_oe            <= 1'b0;
      subscriber_open_drain    <= 1'b0;
      subscriber_run           <= 1'b0;
      pcm_run                  <= 1'b0;
      monitor_handshake_select <= 1'b0;
      mem_we         <= 1'b0;
      mem_broadcast  <= 1'b0;
      mem_addr       <= 8'h00;
      mem_data       <= 8'h00;
      mem_code       <= 4'h0;
      mem_busy       <= 1'b0;
      external_reset_output <= 1'b0;
    end else if (ce) begin
      omc_reg        <= omc_next;
      cmd_reg        <= cmd_next;
      maddr_reg      <= maddr_next;
      mdata_reg      <= mdata_next;
      init_req_reg   <= init_req_next;
      ext_rst_reg    <= ext_rst_next;
      wr_d_reg       <= wr_d_next;
      rdata_reg      <= rdata_next;
      clear_run_reg  <= clear_run_next;
      tri_run_reg    <= tri_run_next;
      // clock fault and receive pins: two stages before use
      fault_s1_reg   <= clock_fault;
      fault_s2_reg   <= fault_s1_reg;
      rx_s1_reg      <= pcm_rx_pin;
      rx_s2_reg      <= rx_s1_reg;
      pcm_rx_data    <= rx_mux;
      pcm_tx_out     <= tx_out_next;
      pcm_tx_oe      <= tx_oe_next;
      tristate_control_pin     <= tctl_next;
      subscriber_oe            <= dec_sub_drive;
      subscriber_open_drain    <= omc_reg[OMC_OPEN_DRAIN];
      subscriber_run           <= dec_sub_run;
      pcm_run                  <= dec_pcm_run;
      monitor_handshake_select <= omc_reg[OMC_MON_HS];
      mem_we         <= timer_busy || timer_start;
      mem_broadcast  <= clear_run_next || dec_bcast;
      mem_addr       <= maddr_next;
      mem_data       <= mdata_next;
      mem_code       <= clear_run_next ? CODE_UNASSIGNED : cmd_next[3:0];
      mem_busy       <= timer_busy || timer_start;
      external_reset_output <= ext_rst_next;
    end
  end

  assign rdata = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_reset_halts: assert property (@(posedge mclk) disable iff (!rst_n)
    (omc_reg[7:6] == 2'b00) |=> !subscriber_run && !pcm_run)
    else $error("interfaces run in reset mode");
  chk_standby_float: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !omc_reg[OMC_PCM_STBY]) |=> pcm_tx_oe == 4'h0 && tristate_control_pin)
    else $error("pcm outputs driven in standby");
  chk_sub_float: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !omc_reg[OMC_SUB_STBY]) |=> !subscriber_oe)
    else $error("subscriber outputs driven in standby");
  chk_ext_reset_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && interrupt_event && !wr_strobe) |=> !external_reset_output)
    else $error("external reset not released");
  chk_clear_time: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(clear_run_reg) |-> ##[1:256] !clear_run_reg)
    else $error("memory clear too slow");
  chk_fault_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && fault_s2_reg) |=> init_req_reg)
    else $error("init flag not set by fault");
  chk_version_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && rd_sel && eff_addr == ADDR_VERSION_AND_INIT_STATUS) |=> rdata[3:0] == VERSION_CODE)
    else $error("version field wrong");
  chk_loop_data: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && omc_reg[OMC_PCM_LOOP]) |=> pcm_rx_data == $past(pcm_tx_data))
    else $error("loop data wrong");
endmodule

/* bench/test_switch_mode_regs.sv */
module test_switch_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import mode_regs_pkg::*;

  localparam logic [3:0] VER = 4'h9;  // arbitrary value
  localparam logic [4:0] A_OMC = ADDR_OPERATION_MODE_CONTROL;
  localparam logic [4:0] A_VNS = ADDR_VERSION_AND_INIT_STATUS;

  logic       mclk, rst_n, ce, cs_n, wr_n, rd_n, demux_mode;
  logic       clock_fault, interrupt_event, tristate_init_req;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, mem_addr, mem_data, rv, ma, md;
  logic [3:0] pcm_rx_pin, pcm_tx_data, pcm_tx_float, pcm_rx_data, pcm_tx_out, pcm_tx_oe;
  logic [3:0] mem_code, mc;
  logic       tristate_control_pin, subscriber_oe, subscriber_open_drain, subscriber_run;
  logic       pcm_run, monitor_handshake_select, mem_we, mem_broadcast, mem_busy;
  logic       external_reset_output, bc, we;
  int         fail_count, total_checks, cnt;

  switch_mode_regs #(.VERSION_CODE(VER)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .demux_mode(demux_mode), .wdata(wdata), .rdata(rdata),
    .clock_fault(clock_fault), .interrupt_event(interrupt_event),
    .tristate_init_req(tristate_init_req), .pcm_rx_pin(pcm_rx_pin),
    .pcm_tx_data(pcm_tx_data), .pcm_tx_float(pcm_tx_float), .pcm_rx_data(pcm_rx_data),
    .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe),
    .tristate_control_pin(tristate_control_pin), .subscriber_oe(subscriber_oe),
    .subscriber_open_drain(subscriber_open_drain), .subscriber_run(subscriber_run),
    .pcm_run(pcm_run), .monitor_handshake_select(monitor_handshake_select),
    .mem_we(mem_we), .mem_broadcast(mem_broadcast), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_code(mem_code), .mem_busy(mem_busy),
    .external_reset_output(external_reset_output)
  );

  // ----------------------------------------------------------------
  // clock, comparison and bus tasks
  // ----------------------------------------------------------------
  // 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one write per low phase: strobe held for exactly one sampling edge
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    @(posedge mclk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
  endtask

  // rdata is registered, so it is taken one edge after the read edge
  task automatic rd_reg(input logic [4:0] a);
    @(posedge mclk);
    addr <= a;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rv = rdata;
    @(posedge mclk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask

  // length of one busy window, with the access fields seen in its first cycle
  task automatic measure();
    cnt = 0;
    bc = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge mclk);
      if (mem_busy === 1'b1) begin
        if (cnt == 0) begin
          bc = mem_broadcast;
          ma = mem_addr;
          md = mem_data;
          mc = mem_code;
          we = mem_we;
        end
        cnt++;
      end else if (cnt > 0) begin
        break;
      end
    end
  endtask

  task automatic in_range(input int lo, input int hi);
    check({15'h0, (cnt >= lo && cnt <= hi)}, 16'h1);
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the longest access is about 2 k cycles, whole run ~3.5 k
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, clock_fault, interrupt_event, tristate_init_req, demux_mode} = '0;
    {ce, cs_n, wr_n, rd_n} = 4'hf;
    {addr, wdata, pcm_rx_pin, pcm_tx_data, pcm_tx_float} = '0;
    repeat (20) @(posedge mclk);
    check(tristate_control_pin, 16'h1);
    check(pcm_tx_oe, 16'h0);
    check(subscriber_oe, 16'h0);
    check({pcm_run, subscriber_run}, 16'h0);
    rst_n <= 1'b1;
    rd_reg(A_OMC);
    check(rv, OMC_RESET);
    rd_reg(A_VNS);
    check(rv, {1'b1, 3'h0, VER});
    rd_reg(A_VNS);
    check(rv, {1'b1, 3'h0, VER});
    rd_reg(5'h05);
    check(rv, 16'h0);
    // standby bits set, yet clear mode keeps both interfaces halted
    wr_reg(A_OMC, 8'h22);
    repeat (2) @(posedge mclk);
    check({pcm_run, subscriber_run}, 16'h0);
    wr_reg(ADDR_MEMORY_ACCESS_DATA, 8'ha5);
    wr_reg(ADDR_MEMORY_ACCESS_COMMAND, 8'h70);
    measure();
    in_range(1, MEM_CLEAR_CYCLES);
    check(bc, 16'h1);
    check(mc, CODE_UNASSIGNED);
    check(md, 8'ha5);
    check(we, 16'h1);
    rd_reg(A_VNS);
    check(rv, {1'b0, 3'h0, VER});
    // fault pin goes through a synchroniser, so hold it a few cycles
    @(posedge mclk) clock_fault <= 1'b1;
    repeat (4) @(posedge mclk);
    clock_fault <= 1'b0;
    rd_reg(A_VNS);
    check(rv, {1'b1, 3'h0, VER});
    // normal mode, both standbys off, open drain, handshake on
    @(posedge mclk);
    pcm_tx_data <= 4'ha;
    pcm_tx_float <= 4'h3;
    pcm_rx_pin <= 4'h5;
    wr_reg(A_OMC, 8'hee);
    repeat (4) @(posedge mclk);
    check({pcm_run, subscriber_run}, 16'h3);
    check(subscriber_oe, 16'h1);
    check(subscriber_open_drain, 16'h1);
    check(monitor_handshake_select, 16'h1);
    check(pcm_tx_oe, 16'hc);
    check(pcm_tx_out, 16'ha);
    check(pcm_rx_data, 16'h5);
    check(tristate_control_pin, 16'h0);
    wr_reg(ADDR_MEMORY_ACCESS_ADDRESS, 8'h41);
    wr_reg(ADDR_MEMORY_ACCESS_COMMAND, 8'h10);
    measure();
    in_range(NORM_CYCLES - 1, NORM_CYCLES + 1);
    check({bc, ma}, {1'b0, 8'h41});
    check(mem_we, 16'h0);
    @(posedge mclk) tristate_init_req <= 1'b1;
    @(posedge mclk) tristate_init_req <= 1'b0;
    measure();
    in_range(TRISTATE_CYCLES - 1, TRISTATE_CYCLES + 1);
    // loop on: external receive data must be ignored
    wr_reg(A_OMC, 8'hfe);
    repeat (4) @(posedge mclk);
    check(pcm_rx_data, 16'ha);
    check(pcm_tx_out, 16'ha);
    // normal mode with every option bit cleared
    wr_reg(A_OMC, 8'hc0);
    repeat (2) @(posedge mclk);
    check({pcm_tx_oe, tristate_control_pin}, 16'h1);
    check(subscriber_oe, 16'h0);
    check(subscriber_open_drain, 16'h0);
    check(monitor_handshake_select, 16'h0);
    // single-address fast mode
    wr_reg(A_OMC, 8'h80);
    wr_reg(ADDR_MEMORY_ACCESS_ADDRESS, 8'h3c);
    wr_reg(ADDR_MEMORY_ACCESS_COMMAND, 8'h10);
    measure();
    in_range(1, INIT_CYCLES);
    check({bc, ma}, {1'b0, 8'h3c});
    check(pcm_run, 16'h0);
    // broadcast test mode, the longest access of all
    wr_reg(A_OMC, 8'h40);
    wr_reg(ADDR_MEMORY_ACCESS_COMMAND, 8'h10);
    measure();
    in_range(TEST_CYCLES - 1, TEST_CYCLES + 1);
    check(bc, 16'h1);
    check(pcm_run, 16'h1);
    // software reset pin holds until an interrupt comes along
    wr_reg(A_VNS, 8'h10);
    repeat (2) @(posedge mclk);
    check(external_reset_output, 16'h1);
    rd_reg(A_VNS);
    check(rv, {1'b1, 3'h0, VER});
    check(external_reset_output, 16'h1);
    @(posedge mclk) interrupt_event <= 1'b1;
    @(posedge mclk) interrupt_event <= 1'b0;
    repeat (2) @(posedge mclk);
    check(external_reset_output, 16'h0);
    // bank bit lifts address 0x0d onto the status register
    @(posedge mclk) demux_mode <= 1'b1;
    wr_reg(A_OMC, 8'hc1);
    rd_reg(5'h0d);
    check(rv, {1'b1, 3'h0, VER});
    @(posedge mclk) demux_mode <= 1'b0;
    rd_reg(5'h0d);
    check(rv, 16'h0);
    give_verdict();
  end
endmodule
